// file: rbc_blend_csc.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01: Green-to-blue and red-to-blue weights, signed Q8.
// RULE_02: Blue-to-blue weight, resets to unity.
// RULE_03: Red and green blend offsets, reset zero.
// RULE_04: Blue blend offset, low bits, reset zero.
// RULE_05: Luma from three signed Q8 coefficients.
// RULE_06: Blue-difference chroma from three coefficients.
// RULE_07: Red-difference chroma, same field layout.
// RULE_08: Signed 8-bit DC offset added to luma.
// RULE_09: Signed DC offset added to blue chroma.
// RULE_10: Signed DC offset added to red chroma.
// RULE_11: Other six blend weights reset to unity.
// RULE_12: Blend is weighted sum plus offset, saturated.
// RULE_13: Converted values saturate to 8 bits; reserved zero.

// Three-term signed dot product with offset, rounding and saturation to unsigned OW bits.
module rbc_dot3 #(
  parameter int CW  = 12,
  parameter int IW  = 10,
  parameter int OFW = 10,
  parameter int OW  = 10,
  parameter int SH  = 8
) (
  // Coefficients and offset
  input  wire logic signed [CW-1:0]  c0,
  input  wire logic signed [CW-1:0]  c1,
  input  wire logic signed [CW-1:0]  c2,
  input  wire logic signed [OFW-1:0] off,
  // Samples
  input  wire logic        [IW-1:0]  x0,
  input  wire logic        [IW-1:0]  x1,
  input  wire logic        [IW-1:0]  x2,
  // Result
  output logic             [OW-1:0]  y
);
  localparam int AW = CW + IW + OFW + SH;
  localparam logic signed [AW-1:0] ONE  = {{(AW-1){1'b0}}, 1'b1};
  localparam logic signed [AW-1:0] RND  = ONE <<< (SH - 1);
  localparam logic signed [AW-1:0] MAXV = {{(AW-OW){1'b0}}, {OW{1'b1}}};

  wire logic signed [AW-1:0] p0  = AW'(c0) * AW'($signed({1'b0, x0}));
  wire logic signed [AW-1:0] p1  = AW'(c1) * AW'($signed({1'b0, x1}));
  wire logic signed [AW-1:0] p2  = AW'(c2) * AW'($signed({1'b0, x2}));
  // The offset joins before rounding so that one rounding step covers the whole sum.
  wire logic signed [AW-1:0] acc = p0 + p1 + p2 + (AW'(off) <<< SH) + RND;
  wire logic signed [AW-1:0] shr = acc >>> SH;

  assign y = (shr < 0) ? '0 : ((shr > MAXV) ? OW'(MAXV) : OW'(shr)); // RULE_12 RULE_13
endmodule

// Flip-flop FIFO with valid and ready on both sides.
module rbc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // Fill side
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [W-1:0]  wr_data,
  // Drain side
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [W-1:0]       rd_data,
  // Fill level
  output logic [AW:0]        level
);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   cnt_q;

  wire logic push = ce & wr_valid & wr_ready;
  wire logic pop  = ce & rd_valid & rd_ready;

  assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem_q[rd_ptr_q];
  assign level    = cnt_q;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

module rbc_blend_csc (
  // Clock, reset and enable
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // Register port
  input  wire logic [rbc_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [rbc_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [rbc_pkg::DATA_W-1:0]    reg_rdata,
  // Pixel input
  input  wire logic                          in_valid,
  input  wire rbc_pkg::rbc_rgb_t             in_pix,
  output logic                               in_ready,
  // Pixel output
  output logic                               out_valid,
  output rbc_pkg::rbc_ycc_t                  out_pix,
  input  wire logic                          out_ready
);
  rbc_pkg::rbc_cfg_t                cfg_q;
  rbc_pkg::rbc_cfg_t                cfg_d;
  logic [rbc_pkg::DATA_W-1:0]       rdata_q;
  logic                             in_ready_q;
  logic                             s1_v_q;
  logic                             s2_v_q;
  rbc_pkg::rbc_rgb_t                s1_pix_q;
  rbc_pkg::rbc_ycc_t                s2_pix_q;
  logic                             out_v_q;
  rbc_pkg::rbc_ycc_t                out_pix_q;
  rbc_pkg::rbc_rgb_t                blend_d;
  rbc_pkg::rbc_ycc_t                ycc_d;
  logic                             f_wr_ready;
  logic                             f_rd_valid;
  logic [rbc_pkg::FIFO_W-1:0]       f_rd_data;
  logic [rbc_pkg::FIFO_AW:0]        f_level;

  // Register decode.
  wire logic hit_mat1  = reg_wr && (reg_addr == rbc_pkg::OFF_MAT1);
  wire logic hit_mat2  = reg_wr && (reg_addr == rbc_pkg::OFF_MAT2);
  wire logic hit_mat3  = reg_wr && (reg_addr == rbc_pkg::OFF_MAT3);
  wire logic hit_mat4  = reg_wr && (reg_addr == rbc_pkg::OFF_MAT4);
  wire logic hit_mat5  = reg_wr && (reg_addr == rbc_pkg::OFF_MAT5);
  wire logic hit_boff1 = reg_wr && (reg_addr == rbc_pkg::OFF_BOFF1);
  wire logic hit_boff2 = reg_wr && (reg_addr == rbc_pkg::OFF_BOFF2);
  wire logic hit_luma_coefficients  = reg_wr && (reg_addr == rbc_pkg::OFF_LUMA_COEFFICIENTS);
  wire logic hit_cb_coefficients  = reg_wr && (reg_addr == rbc_pkg::OFF_CB_COEFFICIENTS);
  wire logic hit_cr_coefficients  = reg_wr && (reg_addr == rbc_pkg::OFF_CR_COEFFICIENTS);
  wire logic hit_dc    = reg_wr && (reg_addr == rbc_pkg::OFF_DCOFF);

  wire logic [rbc_pkg::WT_W-1:0]   w_hi = reg_wdata[rbc_pkg::HI_LSB +: rbc_pkg::WT_W];
  wire logic [rbc_pkg::WT_W-1:0]   w_lo = reg_wdata[rbc_pkg::LO_LSB +: rbc_pkg::WT_W];
  wire logic [rbc_pkg::BOFF_W-1:0] o_hi = reg_wdata[rbc_pkg::HI_LSB +: rbc_pkg::BOFF_W];
  wire logic [rbc_pkg::BOFF_W-1:0] o_lo = reg_wdata[rbc_pkg::LO_LSB +: rbc_pkg::BOFF_W];
  wire logic [rbc_pkg::CSC_W-1:0]  c_b  = reg_wdata[rbc_pkg::CSC_B_LSB +: rbc_pkg::CSC_W];
  wire logic [rbc_pkg::CSC_W-1:0]  c_g  = reg_wdata[rbc_pkg::CSC_G_LSB +: rbc_pkg::CSC_W];
  wire logic [rbc_pkg::CSC_W-1:0]  c_r  = reg_wdata[rbc_pkg::CSC_R_LSB +: rbc_pkg::CSC_W];

  always_comb begin
    cfg_d = cfg_q;
    if (hit_mat1) begin
      cfg_d.weight_green_to_red = w_hi; // RULE_11
      cfg_d.weight_red_to_red   = w_lo; // RULE_11
    end
    if (hit_mat2) begin
      cfg_d.weight_red_to_green = w_hi; // RULE_11
      cfg_d.weight_blue_to_red  = w_lo; // RULE_11
    end
    if (hit_mat3) begin
      cfg_d.weight_blue_to_green  = w_hi; // RULE_11
      cfg_d.weight_green_to_green = w_lo; // RULE_11
    end
    if (hit_mat4) begin
      cfg_d.weight_green_to_blue = w_hi; // RULE_01
      cfg_d.weight_red_to_blue   = w_lo; // RULE_01
    end
    if (hit_mat5) begin
      cfg_d.weight_blue_to_blue = w_lo; // RULE_02
    end
    if (hit_boff1) begin
      cfg_d.blend_red_offset   = o_hi; // RULE_03
      cfg_d.blend_green_offset = o_lo; // RULE_03
    end
    if (hit_boff2) begin
      cfg_d.blend_blue_offset = o_lo; // RULE_04
    end
    if (hit_luma_coefficients) begin
      cfg_d.luma_blue_coef  = c_b; // RULE_05
      cfg_d.luma_green_coef = c_g; // RULE_05
      cfg_d.luma_red_coef   = c_r; // RULE_05
    end
    if (hit_cb_coefficients) begin
      cfg_d.cb_blue_coef  = c_b; // RULE_06
      cfg_d.cb_green_coef = c_g; // RULE_06
      cfg_d.cb_red_coef   = c_r; // RULE_06
    end
    if (hit_cr_coefficients) begin
      cfg_d.cr_blue_coef  = c_b; // RULE_07
      cfg_d.cr_green_coef = c_g; // RULE_07
      cfg_d.cr_red_coef   = c_r; // RULE_07
    end
    if (hit_dc) begin
      cfg_d.luma_dc_offset = reg_wdata[rbc_pkg::DC_Y_LSB +: rbc_pkg::DOFF_W];  // RULE_08
      cfg_d.cb_dc_offset   = reg_wdata[rbc_pkg::DC_CB_LSB +: rbc_pkg::DOFF_W]; // RULE_09
      cfg_d.cr_dc_offset   = reg_wdata[rbc_pkg::DC_CR_LSB +: rbc_pkg::DOFF_W]; // RULE_10
    end
  end

  // Read selection; reserved bits and unmapped offsets read as zero.
  wire logic [rbc_pkg::DATA_W-1:0] status_w = rbc_pkg::DATA_W'({out_v_q, in_ready_q, 2'b00, f_level});
  wire logic [rbc_pkg::DATA_W-1:0] rd_word =
    (reg_addr == rbc_pkg::OFF_MAT1)   ? {4'h0, cfg_q.weight_green_to_red, 4'h0, cfg_q.weight_red_to_red} :
    (reg_addr == rbc_pkg::OFF_MAT2)   ? {4'h0, cfg_q.weight_red_to_green, 4'h0, cfg_q.weight_blue_to_red} :
    (reg_addr == rbc_pkg::OFF_MAT3)   ? {4'h0, cfg_q.weight_blue_to_green, 4'h0, cfg_q.weight_green_to_green} :
    (reg_addr == rbc_pkg::OFF_MAT4)   ? {4'h0, cfg_q.weight_green_to_blue, 4'h0, cfg_q.weight_red_to_blue} :
    (reg_addr == rbc_pkg::OFF_MAT5)   ? {20'h00000, cfg_q.weight_blue_to_blue} :
    (reg_addr == rbc_pkg::OFF_BOFF1)  ? {6'h00, cfg_q.blend_red_offset, 6'h00, cfg_q.blend_green_offset} :
    (reg_addr == rbc_pkg::OFF_BOFF2)  ? {22'h000000, cfg_q.blend_blue_offset} :
    (reg_addr == rbc_pkg::OFF_LUMA_COEFFICIENTS)   ? {2'b00, cfg_q.luma_blue_coef, cfg_q.luma_green_coef, cfg_q.luma_red_coef} :
    (reg_addr == rbc_pkg::OFF_CB_COEFFICIENTS)   ? {2'b00, cfg_q.cb_blue_coef, cfg_q.cb_green_coef, cfg_q.cb_red_coef} :
    (reg_addr == rbc_pkg::OFF_CR_COEFFICIENTS)   ? {2'b00, cfg_q.cr_blue_coef, cfg_q.cr_green_coef, cfg_q.cr_red_coef} :
    (reg_addr == rbc_pkg::OFF_DCOFF)  ? {8'h00, cfg_q.luma_dc_offset, cfg_q.cb_dc_offset, cfg_q.cr_dc_offset} :
    (reg_addr == rbc_pkg::OFF_STATUS) ? status_w : '0; // RULE_13

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= rbc_pkg::CFG_RESET; // RULE_02 RULE_05 RULE_11
      rdata_q <= '0;
    end else if (ce) begin
      cfg_q   <= cfg_d;
      rdata_q <= reg_rd ? rd_word : '0;
    end
  end

  // Blend stage.
  rbc_dot3 #(.CW(rbc_pkg::WT_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::BOFF_W), .OW(rbc_pkg::PIX_W),
             .SH(rbc_pkg::BLEND_SH)) u_bl_r (
    .c0(cfg_q.weight_red_to_red), .c1(cfg_q.weight_green_to_red), .c2(cfg_q.weight_blue_to_red),
    .off(cfg_q.blend_red_offset), .x0(in_pix.r), .x1(in_pix.g), .x2(in_pix.b), .y(blend_d.r)); // RULE_12
  rbc_dot3 #(.CW(rbc_pkg::WT_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::BOFF_W), .OW(rbc_pkg::PIX_W),
             .SH(rbc_pkg::BLEND_SH)) u_bl_g (
    .c0(cfg_q.weight_red_to_green), .c1(cfg_q.weight_green_to_green), .c2(cfg_q.weight_blue_to_green),
    .off(cfg_q.blend_green_offset), .x0(in_pix.r), .x1(in_pix.g), .x2(in_pix.b), .y(blend_d.g));
  rbc_dot3 #(.CW(rbc_pkg::WT_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::BOFF_W), .OW(rbc_pkg::PIX_W),
             .SH(rbc_pkg::BLEND_SH)) u_bl_b (
    .c0(cfg_q.weight_red_to_blue), .c1(cfg_q.weight_green_to_blue), .c2(cfg_q.weight_blue_to_blue),
    .off(cfg_q.blend_blue_offset), .x0(in_pix.r), .x1(in_pix.g), .x2(in_pix.b), .y(blend_d.b)); // RULE_04

  // Conversion stage; the extra shift maps the 10-bit pixel range onto 8-bit outputs.
  rbc_dot3 #(.CW(rbc_pkg::CSC_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::DOFF_W), .OW(rbc_pkg::YCC_W),
             .SH(rbc_pkg::CSC_SH)) u_cs_y (
    .c0(cfg_q.luma_red_coef), .c1(cfg_q.luma_green_coef), .c2(cfg_q.luma_blue_coef),
    .off(cfg_q.luma_dc_offset), .x0(s1_pix_q.r), .x1(s1_pix_q.g), .x2(s1_pix_q.b), .y(ycc_d.y)); // RULE_05 RULE_08
  rbc_dot3 #(.CW(rbc_pkg::CSC_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::DOFF_W), .OW(rbc_pkg::YCC_W),
             .SH(rbc_pkg::CSC_SH)) u_cs_cb (
    .c0(cfg_q.cb_red_coef), .c1(cfg_q.cb_green_coef), .c2(cfg_q.cb_blue_coef),
    .off(cfg_q.cb_dc_offset), .x0(s1_pix_q.r), .x1(s1_pix_q.g), .x2(s1_pix_q.b), .y(ycc_d.cb)); // RULE_06 RULE_09
  rbc_dot3 #(.CW(rbc_pkg::CSC_W), .IW(rbc_pkg::PIX_W), .OFW(rbc_pkg::DOFF_W), .OW(rbc_pkg::YCC_W),
             .SH(rbc_pkg::CSC_SH)) u_cs_cr (
    .c0(cfg_q.cr_red_coef), .c1(cfg_q.cr_green_coef), .c2(cfg_q.cr_blue_coef),
    .off(cfg_q.cr_dc_offset), .x0(s1_pix_q.r), .x1(s1_pix_q.g), .x2(s1_pix_q.b), .y(ycc_d.cr)); // RULE_07 RULE_10

  // The stages never stall, so acceptance stops early enough that every pixel in flight fits the FIFO.
  wire logic acc_in     = ce & in_valid & in_ready_q;
  wire logic in_ready_d = f_wr_ready & (f_level <= rbc_pkg::FIFO_LIMIT);
  wire logic drain      = !out_v_q | out_ready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready_q <= 1'b0;
      s1_v_q     <= 1'b0;
      s2_v_q     <= 1'b0;
      s1_pix_q   <= '0;
      s2_pix_q   <= '0;
      out_v_q    <= 1'b0;
      out_pix_q  <= '0;
    end else if (ce) begin
      in_ready_q <= in_ready_d;
      s1_v_q     <= acc_in;
      s2_v_q     <= s1_v_q;
      if (acc_in) begin
        s1_pix_q <= blend_d;
      end
      if (s1_v_q) begin
        s2_pix_q <= ycc_d;
      end
      if (drain) begin
        out_v_q <= f_rd_valid;
        if (f_rd_valid) begin
          out_pix_q <= f_rd_data;
        end
      end
    end
  end

  rbc_fifo #(.W(rbc_pkg::FIFO_W), .DEPTH(rbc_pkg::FIFO_DEPTH), .AW(rbc_pkg::FIFO_AW)) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .wr_valid (s2_v_q),
    .wr_ready (f_wr_ready),
    .wr_data  (s2_pix_q),
    .rd_valid (f_rd_valid),
    .rd_ready (drain),
    .rd_data  (f_rd_data),
    .level    (f_level)
  );

  assign reg_rdata = rdata_q;
  assign in_ready  = in_ready_q;
  assign out_valid = out_v_q;
  assign out_pix   = out_pix_q;

  // Checks.
  logic wr_seen_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_q <= 1'b0;
    end else if (ce && reg_wr) begin
      wr_seen_q <= 1'b1;
    end
  end

  default clocking cb_chk @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_mat4_readback: assert property ( // RULE_01
    (ce && reg_wr && reg_addr == rbc_pkg::OFF_MAT4) ##1 !reg_wr ##1 (ce && reg_rd && reg_addr == rbc_pkg::OFF_MAT4)
    |=> reg_rdata == ($past(reg_wdata, 3) & rbc_pkg::MASK_MAT))
    else $error("blend weight word did not read back");
  chk_bb_reset_val: assert property ( // RULE_02
    (ce && reg_rd && !wr_seen_q && reg_addr == rbc_pkg::OFF_MAT5) |=> reg_rdata == rbc_pkg::RST_MAT5)
    else $error("blue weight reset value wrong");
  chk_boff_reset: assert property ( // RULE_03
    (ce && reg_rd && !wr_seen_q && reg_addr == rbc_pkg::OFF_BOFF1) |=> reg_rdata == rbc_pkg::RST_ZERO)
    else $error("red green offsets not zero after reset");
  chk_offb_readback: assert property ( // RULE_04
    (ce && reg_wr && reg_addr == rbc_pkg::OFF_BOFF2) ##1 !reg_wr ##1 (ce && reg_rd && reg_addr == rbc_pkg::OFF_BOFF2)
    |=> reg_rdata == ($past(reg_wdata, 3) & rbc_pkg::MASK_LO10))
    else $error("blue offset did not read back");
  chk_luma_reset: assert property ( // RULE_05
    (ce && reg_rd && !wr_seen_q && reg_addr == rbc_pkg::OFF_LUMA_COEFFICIENTS) |=> reg_rdata == rbc_pkg::RST_LUMA_COEFFICIENTS)
    else $error("luma coefficients reset wrong");
  chk_cb_readback: assert property ( // RULE_06
    (ce && reg_wr && reg_addr == rbc_pkg::OFF_CB_COEFFICIENTS) ##1 !reg_wr ##1 (ce && reg_rd && reg_addr == rbc_pkg::OFF_CB_COEFFICIENTS)
    |=> reg_rdata == ($past(reg_wdata, 3) & rbc_pkg::MASK_CSC))
    else $error("cb coefficients did not read back");
  chk_cr_readback: assert property ( // RULE_07
    (ce && reg_wr && reg_addr == rbc_pkg::OFF_CR_COEFFICIENTS) ##1 !reg_wr ##1 (ce && reg_rd && reg_addr == rbc_pkg::OFF_CR_COEFFICIENTS)
    |=> reg_rdata == ($past(reg_wdata, 3) & rbc_pkg::MASK_CSC))
    else $error("cr coefficients did not read back");
  chk_dc_readback: assert property ( // RULE_08
    (ce && reg_wr && reg_addr == rbc_pkg::OFF_DCOFF) ##1 !reg_wr ##1 (ce && reg_rd && reg_addr == rbc_pkg::OFF_DCOFF)
    |=> reg_rdata == ($past(reg_wdata, 3) & rbc_pkg::MASK_DC))
    else $error("dc offsets did not read back");
  chk_blend_zero_in: assert property ( // RULE_12
    (acc_in && in_pix == '0 && cfg_q.blend_red_offset <= 0 && cfg_q.blend_green_offset <= 0
     && cfg_q.blend_blue_offset <= 0) |=> s1_pix_q == '0)
    else $error("black pixel did not blend to black");
  chk_reserved_zero: assert property ( // RULE_13
    (ce && reg_rd && reg_addr != rbc_pkg::OFF_STATUS) |=> reg_rdata[rbc_pkg::DATA_W-1 -: 2] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_fifo_no_drop: assert property ( // RULE_12
    (ce && s2_v_q) |-> f_wr_ready)
    else $error("converted pixel arrived at a full buffer");

  cov_pixel_through: cover property (acc_in ##[3:40] (out_v_q && out_ready));
  cov_fifo_limit:    cover property (ce && f_level > rbc_pkg::FIFO_LIMIT);
  cov_back_pressure: cover property (out_v_q && !out_ready ##1 out_v_q && !out_ready);
endmodule

// file: rbc_pkg.sv
package rbc_pkg;

  // Bus and datapath widths.
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int PIX_W     = 10;
  localparam int YCC_W     = 8;
  localparam int WT_W      = 12;
  localparam int CSC_W     = 10;
  localparam int BOFF_W    = 10;
  localparam int DOFF_W    = 8;

  // Fixed-point scaling: blend weights are Q8, conversion adds 2 bits to drop to 8-bit outputs.
  localparam int BLEND_SH  = 8;
  localparam int CSC_SH    = 10;

  // Field positions.
  localparam int HI_LSB    = 16;
  localparam int LO_LSB    = 0;
  localparam int CSC_B_LSB = 20;
  localparam int CSC_G_LSB = 10;
  localparam int CSC_R_LSB = 0;
  localparam int DC_Y_LSB  = 16;
  localparam int DC_CB_LSB = 8;
  localparam int DC_CR_LSB = 0;
  localparam int ST_LVL_LSB = 0;
  localparam int ST_RDY_BIT = 8;
  localparam int ST_OUT_BIT = 9;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_MAT1   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MAT2   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MAT3   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MAT4   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MAT5   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BOFF1  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BOFF2  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_LUMA_COEFFICIENTS   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_CB_COEFFICIENTS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CR_COEFFICIENTS   = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_DCOFF  = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h2c;

  // Reset values.
  localparam logic [WT_W-1:0]   WT_UNITY   = 12'h100;
  localparam logic [BOFF_W-1:0] BOFF_RST   = 10'h000;
  localparam logic [DOFF_W-1:0] DOFF_RST   = 8'h00;
  localparam logic [CSC_W-1:0]  Y_B_RST    = 10'h01c;
  localparam logic [CSC_W-1:0]  Y_G_RST    = 10'h098;
  localparam logic [CSC_W-1:0]  Y_R_RST    = 10'h04c;
  localparam logic [CSC_W-1:0]  C_B_RST    = 10'h080;
  localparam logic [CSC_W-1:0]  C_G_RST    = 10'h3ac;
  localparam logic [CSC_W-1:0]  C_R_RST    = 10'h3d4;

  // Read masks and reset words used by the checks.
  localparam logic [DATA_W-1:0] MASK_MAT   = 32'h0fff0fff;
  localparam logic [DATA_W-1:0] MASK_LO12  = 32'h00000fff;
  localparam logic [DATA_W-1:0] MASK_BOFF1 = 32'h03ff03ff;
  localparam logic [DATA_W-1:0] MASK_LO10  = 32'h000003ff;
  localparam logic [DATA_W-1:0] MASK_CSC   = 32'h3fffffff;
  localparam logic [DATA_W-1:0] MASK_DC    = 32'h00ffffff;
  localparam logic [DATA_W-1:0] RST_MAT5   = 32'h00000100;
  localparam logic [DATA_W-1:0] RST_ZERO   = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_LUMA_COEFFICIENTS   = {2'b00, Y_B_RST, Y_G_RST, Y_R_RST};

  // Output buffer.
  localparam int FIFO_W     = 3 * YCC_W;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW    = 5;
  localparam logic [FIFO_AW:0] FIFO_LIMIT = 6'h1c;

  typedef struct packed {
    logic [PIX_W-1:0] r;
    logic [PIX_W-1:0] g;
    logic [PIX_W-1:0] b;
  } rbc_rgb_t;

  typedef struct packed {
    logic [YCC_W-1:0] y;
    logic [YCC_W-1:0] cb;
    logic [YCC_W-1:0] cr;
  } rbc_ycc_t;

  typedef struct packed {
    logic signed [WT_W-1:0]   weight_red_to_red;
    logic signed [WT_W-1:0]   weight_green_to_red;
    logic signed [WT_W-1:0]   weight_red_to_green;
    logic signed [WT_W-1:0]   weight_blue_to_red;
    logic signed [WT_W-1:0]   weight_blue_to_green;
    logic signed [WT_W-1:0]   weight_green_to_green;
    logic signed [WT_W-1:0]   weight_green_to_blue;
    logic signed [WT_W-1:0]   weight_red_to_blue;
    logic signed [WT_W-1:0]   weight_blue_to_blue;
    logic signed [BOFF_W-1:0] blend_red_offset;
    logic signed [BOFF_W-1:0] blend_green_offset;
    logic signed [BOFF_W-1:0] blend_blue_offset;
    logic signed [CSC_W-1:0]  luma_blue_coef;
    logic signed [CSC_W-1:0]  luma_green_coef;
    logic signed [CSC_W-1:0]  luma_red_coef;
    logic signed [CSC_W-1:0]  cb_blue_coef;
    logic signed [CSC_W-1:0]  cb_green_coef;
    logic signed [CSC_W-1:0]  cb_red_coef;
    logic signed [CSC_W-1:0]  cr_blue_coef;
    logic signed [CSC_W-1:0]  cr_green_coef;
    logic signed [CSC_W-1:0]  cr_red_coef;
    logic signed [DOFF_W-1:0] luma_dc_offset;
    logic signed [DOFF_W-1:0] cb_dc_offset;
    logic signed [DOFF_W-1:0] cr_dc_offset;
  } rbc_cfg_t;

  localparam rbc_cfg_t CFG_RESET = '{
    WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY, WT_UNITY,
    BOFF_RST, BOFF_RST, BOFF_RST,
    Y_B_RST, Y_G_RST, Y_R_RST,
    C_B_RST, C_G_RST, C_R_RST,
    C_B_RST, C_G_RST, C_R_RST,
    DOFF_RST, DOFF_RST, DOFF_RST};

endpackage

// file: rbc_pix_peer.sv
`timescale 1ns/10ps
// Upstream pixel source and downstream pixel sink of the colour datapath.
module rbc_pix_peer (
  // Clock and sink control
  input  wire logic               ref_clk,
  input  wire logic               stall,
  // Source side
  output logic                    in_valid,
  output rbc_pkg::rbc_rgb_t       in_pix,
  input  wire logic               in_ready,
  // Sink side
  input  wire logic               out_valid,
  input  wire rbc_pkg::rbc_ycc_t  out_pix,
  output logic                    out_ready
);
  rbc_pkg::rbc_rgb_t tx[$];
  rbc_pkg::rbc_ycc_t rx[$];
  initial in_valid = 1'b0;
  initial in_pix = '0;
  assign out_ready = ~stall;
  // A pixel is held until taken; idle data toggles so a stale value is never mistaken for a new one.
  always @(posedge ref_clk) begin
    if (!in_valid || in_ready) begin
      if (tx.size() > 0) begin
        in_valid <= 1'b1;
        in_pix   <= tx.pop_front();
      end else begin
        in_valid <= 1'b0;
        in_pix   <= ~in_pix;
      end
    end
    if (out_valid && out_ready) rx.push_back(out_pix);
  end
endmodule

// file: rgb_blend_and_ycbcr_convert_tb.sv
`timescale 1ns/10ps
module rgb_blend_and_ycbcr_convert_tb;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, stall = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic in_valid, in_ready, out_valid, out_ready;
  rbc_pkg::rbc_rgb_t in_pix;
  rbc_pkg::rbc_ycc_t out_pix;
  int n_errors = 0, compares = 0;
  int m[3][3], bo[3], c[3][3], dc[3];
  always #4 ref_clk = ~ref_clk;
  rbc_blend_csc rbc_blend_csc_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_pix(in_pix), .in_ready(in_ready), .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
  rbc_pix_peer rbc_pix_peer_inst (.ref_clk(ref_clk), .stall(stall), .in_valid(in_valid), .in_pix(in_pix),
    .in_ready(in_ready), .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    m = '{'{256, 256, 256}, '{256, 256, 256}, '{256, 256, 256}};
    bo = '{0, 0, 0};
    dc = '{0, 0, 0};
    c = '{'{'h4c, 'h98, 'h1c}, '{-44, -84, 128}, '{-44, -84, 128}};
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [31:0] exp_pix(int r, int g, int b);
    int x[3], s;
    logic [31:0] o = 0;
    for (int k = 0; k < 3; k++) begin
      s = (m[k][0] * r + m[k][1] * g + m[k][2] * b + (bo[k] <<< 8) + 128) >>> 8;
      x[k] = s < 0 ? 0 : (s > 1023 ? 1023 : s);
    end
    for (int k = 0; k < 3; k++) begin
      s = (c[k][0] * x[0] + c[k][1] * x[1] + c[k][2] * x[2] + (dc[k] <<< 10) + 512) >>> 10;
      s = s < 0 ? 0 : (s > 255 ? 255 : s);
      o[23 - 8 * k -: 8] = s[7:0];
    end
    return o;
  endfunction
  task automatic t_regs();
    logic [31:0] rv[11] = '{32'h01000100, 32'h01000100, 32'h01000100, 32'h01000100, rbc_pkg::RST_MAT5, 0, 0,
      rbc_pkg::RST_LUMA_COEFFICIENTS, {2'b00, rbc_pkg::C_B_RST, rbc_pkg::C_G_RST, rbc_pkg::C_R_RST},
      {2'b00, rbc_pkg::C_B_RST, rbc_pkg::C_G_RST, rbc_pkg::C_R_RST}, rbc_pkg::RST_ZERO};
    logic [31:0] mk[11] = '{rbc_pkg::MASK_MAT, rbc_pkg::MASK_MAT, rbc_pkg::MASK_MAT, rbc_pkg::MASK_MAT,
      rbc_pkg::MASK_LO12, rbc_pkg::MASK_BOFF1, rbc_pkg::MASK_LO10, rbc_pkg::MASK_CSC, rbc_pkg::MASK_CSC,
      rbc_pkg::MASK_CSC, rbc_pkg::MASK_DC};
    for (int k = 0; k < 11; k++) begin
      rd(8'(4 * k));
      chk("reset value", d, rv[k]);
    end
    // Every reset value is read before the first write, so the reset checks see untouched registers.
    for (int k = 0; k < 11; k++) begin
      wr(8'(4 * k), 32'hffffffff);
      rd(8'(4 * k));
      chk("written value", d, mk[k]);
    end
    rd(8'h30);
    chk("unmapped read", d, 32'h0);
    $display("test registers done");
  endtask
  // With hold set, pixels go in with the sink stalled first, so the buffer must fill and refuse before draining.
  task automatic t_pix(int n, bit hold);
    logic [31:0] q[$];
    rbc_pkg::rbc_rgb_t p;
    stall <= hold;
    for (int i = 0; i < n; i++) begin
      p = (i == 5) ? 30'h0 : {10'(i * 389), 10'(i * 131 + 700), 10'(1023 - i * 53)};
      q.push_back(exp_pix(p.r, p.g, p.b));
      rbc_pix_peer_inst.tx.push_back(p);
    end
    if (hold) begin
      repeat (80) @(posedge ref_clk);
      rd(rbc_pkg::OFF_STATUS);
      chk("input ready when full", d[rbc_pkg::ST_RDY_BIT], 32'h0);
      chk("sink stalled", rbc_pix_peer_inst.rx.size(), 32'h0);
      stall <= 1'b0;
    end
    for (int t = 0; t < 400 && rbc_pix_peer_inst.rx.size() < n; t++) @(posedge ref_clk);
    chk("pixel count", rbc_pix_peer_inst.rx.size(), n);
    while (q.size() > 0 && rbc_pix_peer_inst.rx.size() > 0)
      chk("output pixel", rbc_pix_peer_inst.rx.pop_front(), q.pop_front());
    $display("test pixels done");
  endtask
  task automatic t_prog();
    wr(rbc_pkg::OFF_MAT1, 32'h00000100);
    wr(rbc_pkg::OFF_MAT2, 32'h0);
    wr(rbc_pkg::OFF_MAT3, 32'h00000100);
    wr(rbc_pkg::OFF_MAT4, 32'h00800f80);
    wr(rbc_pkg::OFF_BOFF1, 32'h03f00010);
    wr(rbc_pkg::OFF_BOFF2, 32'h000003ff);
    wr(rbc_pkg::OFF_DCOFF, 32'h0010807f);
    m = '{'{256, 0, 0}, '{0, 256, 0}, '{-128, 128, 256}};
    bo = '{-16, 16, -1};
    dc = '{16, -128, 127};
    t_pix(12, 1'b0);
  endtask
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  initial begin
    do_reset();
    t_regs();
    do_reset();
    t_pix(40, 1'b1);
    t_prog();
    test_done();
  end
endmodule
